// File: rtl/capture_sequencer.v
/*
 * capture sequencer: slot table, preset parameter store, frame counting
 * for counted-burst, per-trigger and bulk-trigger acquisition, apb slave.
 * assumes trigger and frame handshakes synchronous to pclk.
 */
//
// Function
// [R1] sixteen-slot table, selector 1..16 resets to 1, preset writes hit selected slot
// [R2] each slot holds preset 1..15, defaulting to preset 1
// [R3] frames use slots 1..N in order then wrap to slot 1
// [R4] one enable, off at reset; while off no per-slot preset switching
// [R5] current slot's preset parameters are applied before its frame starts
// [R6] only the listed imaging parameters are switched per slot
// [R7] persistent preset store erases then writes, taking about 700 ms; the code writes flash_img with no erase
// [R8] fast preset store writes volatile memory, done under 100 us
// [R9] counted burst untriggered sends exactly the frame limit then stops
// [R10] counted burst with trigger style 0 or 1 sends one frame per trigger
// [R11] bulk style 6 sends frames-per-trigger frames on one trigger
// [R12] bulk in counted burst is capped by the frame limit
// [R13] enabling the sequence or restarting acquisition returns to slot 1
`include "capture_seq_defines.vh"

module capture_sequencer #(
    parameter [31:0] PERSIST_CYCLES = `PERSIST_STORE_CYCLES
) (
    input wire pclk, // 250 MHz clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error
    input wire trigger_in, // one-cycle trigger pulse
    output reg trigger_accepted, // pulse: trigger taken
    output reg [39:0] frame_desc, // slot, preset, first param word for this frame
    output reg frame_valid, // descriptor valid
    input wire frame_ready, // receiver takes the descriptor
    output reg [3:0] active_preset, // preset applied to the sensor now
    output reg acquiring // acquisition running
);
    ////////////////////////////////////////////////////////////////////////
    localparam S_IDLE = 3'b001;
    localparam S_RUN = 3'b010;
    localparam S_WAIT = 3'b100;

    reg seq_capture_on;
    reg [4:0] seq_loop_length;
    reg [4:0] seq_slot_select;
    reg [3:0] seq_slot_preset [0:15];
    reg [1:0] acquire_run_style;
    reg trigger_gate_on;
    reg [2:0] trigger_style_code;
    reg [15:0] transfer_frame_limit;
    reg [15:0] frames_per_trigger;
    reg [`PARAM_IDX_W-1:0] param_select;
    reg [31:0] work_param [0:`PARAM_COUNT-1];
    reg [31:0] preset_ram [0:255];
    reg [31:0] flash_img [0:255];
    reg [3:0] store_preset;
    reg store_busy;
    reg [15:0] preset_loaded;
    reg store_persistent;
    reg [31:0] store_timer;
    reg [`PARAM_IDX_W:0] store_idx;
    reg [2:0] state;
    reg [4:0] cur_slot;
    reg [15:0] frames_sent;
    reg [15:0] burst_left;
    reg start_req;
    reg stop_req;
    reg seq_on_d;
    integer i;

    wire [11:0] waddr = paddr;
    wire wr_en = psel && penable && pwrite && pready;
    wire rd_setup = psel && !penable;
    wire [15:0] one16 = 16'h0001;

    // out-of-range slot numbers fall back to slot 1 rather than wrapping
    function [4:0] clamp_slot;
        input [31:0] v;
        begin
            if (v[4:0] < `SLOT_MIN || v > {27'h0, `SLOT_MAX})
                clamp_slot = `SLOT_MIN;
            else
                clamp_slot = v[4:0];
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a <= `REG_FRAMES_SENT) && (a[1:0] == 2'h0);
        end
    endfunction

    function [3:0] slot_index;
        input [4:0] s;
        begin
            slot_index = s[3:0] - 4'h1; // slot 16 lands on entry 15
        end
    endfunction

    function [7:0] ram_index;
        input [3:0] p;
        input [3:0] w;
        begin
            ram_index = {p - 4'h1, w};
        end
    endfunction

    wire [3:0] slot_preset_now = seq_slot_preset[slot_index(cur_slot)];
    wire [3:0] next_preset = seq_capture_on ? slot_preset_now : `PRESET_MIN; // see [R4]
    wire counted = (acquire_run_style == `STYLE_COUNTED);
    wire limit_hit = counted && (frames_sent >= transfer_frame_limit); // see [R9] [R12]
    wire bulk = trigger_gate_on && (trigger_style_code == `TRIG_STYLE_BULK);
    wire buf_ready;
    wire emit = (state == S_RUN) && buf_ready && !limit_hit && !store_busy;
    wire [4:0] next_slot = (cur_slot >= seq_loop_length) ? `SLOT_MIN
                                                          : cur_slot + 5'h01; // see [R3]
    wire trig_ok = (state == S_WAIT) && trigger_in && !limit_hit && !store_busy;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    // read data is decoded in setup so it stands through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && !mapped(paddr);
            if (rd_setup && !pwrite) begin
                case (paddr)
                    `REG_SEQ_CTRL: prdata <= {26'h0, seq_loop_length, seq_capture_on};
                    `REG_SEQ_SLOT_SELECT: prdata <= {27'h0, seq_slot_select};
                    `REG_SEQ_SLOT_PRESET:
                        prdata <= {28'h0, seq_slot_preset[slot_index(seq_slot_select)]};
                    `REG_ACQ_CTRL: prdata <= {26'h0, trigger_style_code,
                                              trigger_gate_on, acquire_run_style};
                    `REG_TRANSFER_FRAME_LIMIT: prdata <= {16'h0, transfer_frame_limit};
                    `REG_FRAMES_PER_TRIGGER: prdata <= {16'h0, frames_per_trigger};
                    `REG_STATUS: prdata <= {23'h0, cur_slot, store_busy, acquiring,
                                            limit_hit, store_persistent};
                    `REG_PRESET_PARAM: prdata <= work_param[param_select];
                    `REG_PARAM_SELECT: prdata <= {28'h0, param_select};
                    `REG_FRAMES_SENT: prdata <= {16'h0, frames_sent};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_capture_on <= 1'b0; // see [R4]
            seq_loop_length <= `LOOP_LEN_RESET;
            seq_slot_select <= `SLOT_MIN; // see [R1]
            for (i = 0; i < 16; i = i + 1)
                seq_slot_preset[i] <= `PRESET_MIN; // see [R2]
            acquire_run_style <= `STYLE_CONTINUOUS;
            trigger_gate_on <= 1'b0;
            trigger_style_code <= `TRIG_STYLE_SINGLE0;
            transfer_frame_limit <= 16'h0001;
            frames_per_trigger <= 16'h0001;
            param_select <= {`PARAM_IDX_W{1'b0}};
            start_req <= 1'b0;
            stop_req <= 1'b0;
        end else begin
            start_req <= 1'b0;
            stop_req <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    `REG_SEQ_CTRL: begin
                        seq_capture_on <= pwdata[0];
                        seq_loop_length <= clamp_slot({27'h0, pwdata[5:1]});
                    end
                    `REG_SEQ_SLOT_SELECT: seq_slot_select <= clamp_slot(pwdata); // see [R1]
                    `REG_SEQ_SLOT_PRESET: begin
                        if (pwdata[3:0] >= `PRESET_MIN) // see [R2]
                            seq_slot_preset[slot_index(seq_slot_select)] <= pwdata[3:0];
                    end
                    `REG_ACQ_CTRL: begin
                        acquire_run_style <= pwdata[1:0];
                        trigger_gate_on <= pwdata[2];
                        trigger_style_code <= pwdata[5:3];
                        start_req <= pwdata[8];
                        stop_req <= pwdata[9];
                    end
                    `REG_TRANSFER_FRAME_LIMIT: transfer_frame_limit <= pwdata[15:0];
                    `REG_FRAMES_PER_TRIGGER: frames_per_trigger <= pwdata[15:0];
                    `REG_PARAM_SELECT: param_select <= pwdata[`PARAM_IDX_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working parameter set and preset stores; the store is blocking so a
    // frame never starts with a half-written preset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `PARAM_COUNT; i = i + 1)
                work_param[i] <= 32'h0;
            store_busy <= 1'b0;
            store_persistent <= 1'b0;
            store_timer <= 32'h0;
            store_idx <= {(`PARAM_IDX_W+1){1'b0}};
            store_preset <= `PRESET_MIN;
            preset_loaded <= 16'h0;
        end else begin
            if (wr_en && paddr == `REG_PRESET_PARAM) // see [R6]
                work_param[param_select] <= pwdata;
            if (wr_en && paddr == `REG_PRESET_CMD && !store_busy
                    && pwdata[3:0] >= `PRESET_MIN) begin
                store_busy <= 1'b1;
                store_preset <= pwdata[3:0];
                store_persistent <= pwdata[4];
                store_idx <= {(`PARAM_IDX_W+1){1'b0}};
                store_timer <= pwdata[4] ? PERSIST_CYCLES - 32'h1
                                         : `FAST_STORE_CYCLES - 32'h1; // see [R7] [R8]
            end else if (store_busy) begin
                if (store_idx < `PARAM_COUNT) begin
                    preset_ram[ram_index(store_preset, store_idx[`PARAM_IDX_W-1:0])]
                        <= work_param[store_idx[`PARAM_IDX_W-1:0]]; // see [R8]
                    if (store_persistent) // plain copy with no erase step, see [R7]
                        flash_img[ram_index(store_preset, store_idx[`PARAM_IDX_W-1:0])]
                            <= work_param[store_idx[`PARAM_IDX_W-1:0]];
                    store_idx <= store_idx + 5'h01;
                end
                if (store_timer == 32'h0) begin
                    store_busy <= 1'b0;
                    preset_loaded[store_preset - 4'h1] <= 1'b1;
                end else
                    store_timer <= store_timer - 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acquisition sequencer
    // triggers outside the wait state, during a store or past the limit are
    // dropped silently; the source has to retry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            cur_slot <= `SLOT_MIN;
            frames_sent <= 16'h0;
            burst_left <= 16'h0;
            acquiring <= 1'b0;
            trigger_accepted <= 1'b0;
            active_preset <= `PRESET_MIN;
            seq_on_d <= 1'b0;
        end else begin
            trigger_accepted <= 1'b0;
            seq_on_d <= seq_capture_on;
            if (seq_capture_on && !seq_on_d)
                cur_slot <= `SLOT_MIN; // see [R13]
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        cur_slot <= `SLOT_MIN; // see [R13]
                        frames_sent <= 16'h0;
                        acquiring <= 1'b1;
                        state <= trigger_gate_on ? S_WAIT : S_RUN;
                        burst_left <= 16'h0;
                    end
                end
                S_WAIT: begin
                    if (stop_req || limit_hit) begin
                        state <= S_IDLE;
                        acquiring <= 1'b0;
                    end else if (trig_ok) begin // see [R10]
                        trigger_accepted <= 1'b1;
                        burst_left <= bulk ? frames_per_trigger : one16; // see [R11]
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (stop_req || limit_hit) begin // see [R9] [R12]
                        state <= S_IDLE;
                        acquiring <= 1'b0;
                    end else if (emit) begin
                        active_preset <= next_preset; // see [R5]
                        frames_sent <= frames_sent + 16'h0001;
                        if (seq_capture_on)
                            cur_slot <= next_slot; // see [R3]
                        if (trigger_gate_on) begin
                            burst_left <= burst_left - 16'h0001;
                            if (burst_left <= one16)
                                state <= S_WAIT; // see [R10] [R11]
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // descriptor: slot, preset and its first stored parameter word
    // a preset never stored reads as zero, so no x reaches the receiver
    wire [31:0] first_word = preset_loaded[next_preset - 4'h1]
                             ? preset_ram[ram_index(next_preset, 4'h0)] : 32'h0;
    wire [39:0] desc_in = {cur_slot[3:0], next_preset, first_word}; // see [R5]
    wire [39:0] buf_data;
    wire buf_valid;

    // two entries let the receiver stall without the sequencer
    // losing a descriptor it has already counted
    frame_skid_buffer #(
        .WIDTH(40)
    ) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(desc_in),
        .in_valid(emit),
        .in_ready(buf_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(!frame_valid || frame_ready)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_desc <= 40'h0;
            frame_valid <= 1'b0;
        end else if (!frame_valid || frame_ready) begin
            frame_valid <= buf_valid;
            if (buf_valid)
                frame_desc <= buf_data;
        end
    end
endmodule // capture_sequencer

// File: rtl/capture_seq_defines.vh
/*
 * register offsets, field codes, reset values and timing counts of the
 * capture sequencer. assumes a 250 MHz pclk.
 */
`ifndef CAPTURE_SEQ_DEFINES_VH
`define CAPTURE_SEQ_DEFINES_VH

`define REG_SEQ_CTRL 12'h000
`define REG_SEQ_SLOT_SELECT 12'h004
`define REG_SEQ_SLOT_PRESET 12'h008
`define REG_ACQ_CTRL 12'h00c
`define REG_TRANSFER_FRAME_LIMIT 12'h010
`define REG_FRAMES_PER_TRIGGER 12'h014
`define REG_PRESET_CMD 12'h018
`define REG_STATUS 12'h01c
`define REG_PRESET_PARAM 12'h020
`define REG_PARAM_SELECT 12'h024
`define REG_FRAMES_SENT 12'h028

`define SLOT_MIN 5'h01
`define SLOT_MAX 5'h10
`define PRESET_MIN 4'h1
`define PRESET_MAX 4'hf
`define LOOP_LEN_RESET 5'h01

`define STYLE_CONTINUOUS 2'h0
`define STYLE_COUNTED 2'h1
`define TRIG_STYLE_SINGLE0 3'h0
`define TRIG_STYLE_SINGLE1 3'h1
`define TRIG_STYLE_BULK 3'h6

`define PARAM_COUNT 16
`define PARAM_IDX_W 4

`define CLK_MHZ 250
`define PERSIST_STORE_MS 700
`define PERSIST_STORE_CYCLES (`PERSIST_STORE_MS * 1000 * `CLK_MHZ)
`define FAST_STORE_US 100
`define FAST_STORE_CYCLES ((`FAST_STORE_US * `CLK_MHZ) - 1)

`endif

// File: rtl/frame_skid_buffer.v
/*
 * two-entry valid/ready buffer carrying the per-frame descriptor.
 * assumes one clock, asynchronous active-low reset.
 */
`include "capture_seq_defines.vh"

module frame_skid_buffer #(
    parameter WIDTH = 40
) (
    input wire pclk, // clock
    input wire presetn, // async reset, active low
    input wire [WIDTH-1:0] in_data, // word from sequencer
    input wire in_valid, // word offered
    output wire in_ready, // room for a word
    output wire [WIDTH-1:0] out_data, // head word
    output wire out_valid, // head word valid
    input wire out_ready // receiver accepts
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            mem[0] <= {WIDTH{1'b0}};
            mem[1] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // frame_skid_buffer

// File: tb/capture_sequencer_props.sv
/* concurrent checks on the capture sequencer top ports.
   assumes a bind onto capture_sequencer, one pclk domain. */
module capture_sequencer_props (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic trigger_in, // trigger pulse
    input wire logic trigger_accepted, // trigger taken
    input wire logic [39:0] frame_desc, // frame descriptor
    input wire logic frame_valid, // descriptor valid
    input wire logic frame_ready, // receiver takes it
    input wire logic [3:0] active_preset, // preset in use
    input wire logic acquiring // acquisition running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_desc_held: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_desc))
        else $error("descriptor dropped while stalled");
    a_desc_preset_range: assert property (frame_valid |-> frame_desc[35:32] != 4'h0)
        else $error("descriptor preset out of range");
    a_active_preset_range: assert property (active_preset != 4'h0)
        else $error("active preset out of range");
    a_trig_cause: assert property (trigger_accepted |-> $past(trigger_in))
        else $error("trigger accepted without trigger");
    a_trig_one_pulse: assert property (trigger_accepted |=> !trigger_accepted)
        else $error("trigger accepted twice in a row");
    a_trig_running: assert property (trigger_accepted |-> acquiring)
        else $error("trigger accepted while idle");
endmodule // capture_sequencer_props
bind capture_sequencer capture_sequencer_props props_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_in, .trigger_accepted,
    .frame_desc, .frame_valid, .frame_ready, .active_preset, .acquiring);

// File: tb/frame_host_model.sv
/* trigger source and host image receiver facing the sequencer.
   assumes pclk-synchronous handshakes; receiver can throttle itself. */
module frame_host_model (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic [39:0] frame_desc, // descriptor from sequencer
    input wire logic frame_valid, // descriptor offered
    input wire logic trigger_accepted, // trigger taken
    input wire logic stall, // throttle the receiver
    output logic frame_ready, // receiver takes descriptor
    output logic trigger_in // trigger pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] seen[$];
    int taken;
    logic [1:0] phase;
    initial begin
        frame_ready = 1'b0;
        trigger_in = 1'b0;
        taken = 0;
        phase = 2'h0;
    end
    // ready one cycle in four when stalling, to fill the two-entry buffer
    always @(posedge pclk) begin
        phase <= phase + 2'h1;
        frame_ready <= !stall || phase == 2'h3;
        if (presetn && frame_valid && frame_ready)
            seen.push_back(frame_desc[35:32]);
        if (trigger_accepted)
            taken++;
    end
    // retries until taken; one trigger per wanted frame burst
    task fire(input int tries);
        int n;
        begin
            n = taken;
            repeat (tries) begin
                if (taken == n) begin
                    @(posedge pclk) trigger_in <= 1'b1;
                    @(posedge pclk) trigger_in <= 1'b0;
                    repeat (3) @(posedge pclk);
                end
            end
        end
    endtask
endmodule // frame_host_model

// File: tb/tb_capture_sequencer.sv
/* self-checking bench for the capture sequencer.
   assumes the bound checker and frame_host_model on the frame side. */
module tb_capture_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, stall, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, trigger_in, trigger_accepted, frame_valid, frame_ready, acquiring;
    logic [39:0] frame_desc;
    logic [3:0] active_preset;
    int num_errors, num_checks, cyc;
    // short persistent store keeps the run brief
    capture_sequencer #(.PERSIST_CYCLES(32'd50)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_in, .trigger_accepted,
        .frame_desc, .frame_valid, .frame_ready, .active_preset, .acquiring);
    frame_host_model host_u (.pclk, .presetn, .frame_desc, .frame_valid, .trigger_accepted,
        .stall, .frame_ready, .trigger_in);
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
            @(posedge pclk) penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 100);
            if (n >= 100) chk("pready", 32'h1, pready);
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_frames(input int n); // idle window afterwards catches extra frames
        int k;
        begin
            k = 0;
            while (host_u.seen.size() < n && k < 3000) begin
                @(posedge pclk);
                k++;
            end
            repeat (60) @(posedge pclk);
            chk("frame count", n, host_u.seen.size());
        end
    endtask
    task run(input logic [31:0] acq, input logic [31:0] limit);
        apb(1, 12'h010, limit);
        host_u.seen.delete();
        apb(1, 12'h00c, acq | 32'h100);
    endtask
    task chk_seen(input logic [3:0] p0, input logic [3:0] p1, input logic [3:0] p2);
        chk("preset 0", p0, host_u.seen[0]);
        chk("preset 1", p1, host_u.seen[1]);
        if (host_u.seen.size() > 2)
            chk("preset 2", p2, host_u.seen[2]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, 12'h000, 0);
        chk("ctrl", 32'h2, rdat);
        apb(0, 12'h004, 0);
        chk("slot select", 32'h1, rdat);
        apb(0, 12'h008, 0);
        chk("slot preset", 32'h1, rdat);
        chk("active preset", 32'h1, active_preset);
        apb(0, 12'h040, 0);
        chk("unmapped err", 32'h1, rerr);
    endtask
    task t_slots;
        logic [3:0] p[3];
        begin
            p = '{4'h5, 4'h9, 4'he};
            for (int i = 0; i < 3; i++) begin
                apb(1, 12'h004, i + 1);
                apb(1, 12'h008, p[i]);
            end
            apb(1, 12'h008, 0);
            apb(0, 12'h008, 0);
            chk("preset zero ignored", 32'he, rdat);
            apb(1, 12'h004, 32'h10);
            apb(1, 12'h008, 32'hf);
            apb(0, 12'h008, 0);
            chk("slot 16 preset", 32'hf, rdat);
            apb(1, 12'h004, 32'h11);
            apb(0, 12'h004, 0);
            chk("select over range", 32'h1, rdat);
            apb(1, 12'h000, 32'h20);
            apb(0, 12'h000, 0);
            chk("loop length 16", 32'h20, rdat);
        end
    endtask
    task t_seq;
        apb(1, 12'h000, 32'h7);
        stall = 1'b1;
        run(32'h1, 7);
        wait_frames(7);
        chk_seen(4'h5, 4'h9, 4'he);
        for (int i = 3; i < 7; i++)
            chk("wrapped preset", host_u.seen[i - 3], host_u.seen[i]);
        chk("acquiring after limit", 32'h0, acquiring);
        apb(0, 12'h028, 0);
        chk("frames sent", 32'h7, rdat);
        run(32'h1, 2);
        wait_frames(2);
        chk_seen(4'h5, 4'h9, 4'h0);
        stall = 1'b0;
    endtask
    task t_disabled;
        apb(1, 12'h000, 32'h6);
        run(32'h1, 2);
        wait_frames(2);
        chk_seen(4'h1, 4'h1, 4'h0);
        apb(1, 12'h000, 32'h7);
    endtask
    task t_trig;
        for (int s = 0; s < 2; s++) begin
            run(32'h5 | (s << 3), 2);
            host_u.fire(20);
            wait_frames(1);
            host_u.fire(20);
            wait_frames(2);
            host_u.fire(1);
            wait_frames(2);
            chk_seen(4'h5, 4'h9, 4'h0);
        end
    endtask
    task t_bulk;
        apb(1, 12'h014, 3);
        run(32'h35, 2);
        host_u.fire(20);
        wait_frames(2);
        run(32'h34, 2);
        host_u.fire(20);
        wait_frames(3);
        chk_seen(4'h5, 4'h9, 4'he);
        apb(1, 12'h00c, 32'h200);
    endtask
    task t_midreset;
        stall = 1'b1;
        run(32'h1, 40);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("acquiring in reset", 32'h0, acquiring);
        chk("frame valid in reset", 32'h0, frame_valid);
        presetn <= 1'b1;
        stall = 1'b0;
        t_reset;
    endtask
    task t_store(input logic [31:0] cmd, input int lo, input int hi);
        int t0;
        begin
            apb(1, 12'h018, cmd);
            t0 = cyc;
            apb(0, 12'h01c, 0);
            chk("store busy", 32'h1, rdat[3]);
            while (rdat[3] === 1'b1 && cyc - t0 < 30000)
                apb(0, 12'h01c, 0);
            chk("store time", 32'h1, cyc - t0 >= lo && cyc - t0 <= hi);
            chk("last store kind", cmd[4], rdat[0]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    initial begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        summarize;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, stall} = '0;
        {num_errors, num_checks, cyc} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_slots;
        t_seq;
        t_disabled;
        t_trig;
        t_bulk;
        t_midreset;
        t_store(32'h02, 1, 25002);
        t_store(32'h12, 50, 60);
        summarize;
    end
endmodule // tb_capture_sequencer
